// file: common/rpcia_pkg.sv
/*
 Package for the receive per-channel indirect access block: register
 offsets, field positions, reset values, timing and bus carrier types.
 Assumes an 8-bit register space reached over classic Wishbone, 32-bit data.
*/
package rpcia_pkg;
    // ------------------------------------------------------------
    // Register byte addresses (index times four)
    // ------------------------------------------------------------
    localparam logic [7:0] RPCIA_IDX_CONFIG = 8'h50;
    localparam logic [7:0] RPCIA_IDX_STATUS = 8'h51;
    localparam logic [7:0] RPCIA_IDX_ADDR_CTRL = 8'h52;
    localparam logic [7:0] RPCIA_IDX_DATA_BUF = 8'h53;
    localparam logic [9:0] RPCIA_ADR_CONFIG = {RPCIA_IDX_CONFIG, 2'h0};
    localparam logic [9:0] RPCIA_ADR_STATUS = {RPCIA_IDX_STATUS, 2'h0};
    localparam logic [9:0] RPCIA_ADR_ADDR_CTRL = {RPCIA_IDX_ADDR_CTRL, 2'h0};
    localparam logic [9:0] RPCIA_ADR_DATA_BUF = {RPCIA_IDX_DATA_BUF, 2'h0};
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int RPCIA_BIT_ACCESS_TYPE_SELECT = 1;
    localparam int RPCIA_BIT_PER_CHANNEL_FUNC_ENABLE = 0;
    localparam int RPCIA_BIT_BUSY = 7;
    localparam int RPCIA_BIT_READ_NOT_WRITE = 7;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [1:0] RPCIA_RST_CONFIG = 2'h0;
    localparam logic [7:0] RPCIA_RST_ADDR_CTRL = 8'h00;
    localparam logic [7:0] RPCIA_RST_DATA_BUF = 8'h00;
    // ------------------------------------------------------------
    // Internal index space
    // ------------------------------------------------------------
    localparam logic [6:0] RPCIA_IX_PCM_FIRST = 7'h01;
    localparam logic [6:0] RPCIA_IX_DTC_FIRST = 7'h19;
    localparam logic [6:0] RPCIA_IX_STC_FIRST = 7'h31;
    localparam int RPCIA_NUM_CHAN = 24;
    localparam int RPCIA_NUM_ENTRY = 3 * RPCIA_NUM_CHAN;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int RPCIA_CLK_PERIOD_NS = 50;
    localparam int RPCIA_ACCESS_TIME_NS = 640;
    // Longest time rounds down: 12 cycles
    localparam int RPCIA_ACCESS_CYCLES = RPCIA_ACCESS_TIME_NS / RPCIA_CLK_PERIOD_NS;
    // ------------------------------------------------------------
    // Bus carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [9:0] adr;
        logic [31:0] dat;
    } rpcia_wb_req_t;
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } rpcia_wb_rsp_t;
endpackage : rpcia_pkg

// file: hdl/rpcia_top.sv
/*
 Receive per-channel indirect access: Wishbone register slave, indirect
 access engine for the 72-byte per-channel store, and per-channel
 conditioning of the received data and signalling streams.
 Assumes one 20 MHz clock; stream inputs are on the same clock.
*/
`timescale 1ns/1ps
module rpcia_top (
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    input wire rpcia_pkg::rpcia_wb_req_t WB_REQ,
    output rpcia_pkg::rpcia_wb_rsp_t WB_RSP,
    input wire logic [4:0] CHAN_NUM,
    input wire logic [7:0] RX_PCM_IN,
    input wire logic [3:0] RX_SIG_IN,
    output logic [7:0] BACKPLANE_RX_PCM_OUT,
    output logic [3:0] BACKPLANE_RX_SIG_OUT
);
    import rpcia_pkg::*;

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic access_type_select;
    logic per_channel_func_enable;
    logic [7:0] addr_ctrl;
    logic [7:0] data_buf;
    logic busy;
    logic [3:0] busy_cnt;
    logic [7:0] store [RPCIA_NUM_ENTRY];
    logic wb_ack;
    logic [31:0] wb_dat;

    logic bus_hit;
    logic bus_wr;
    logic start_access;
    logic [6:0] req_index;
    logic req_read;
    logic [6:0] entry;
    logic entry_valid;
    logic done;

    assign bus_hit = WB_REQ.cyc && WB_REQ.stb && !wb_ack;
    assign bus_wr = bus_hit && WB_REQ.we && WB_REQ.sel[0];
    assign req_index = addr_ctrl[6:0];
    assign req_read = addr_ctrl[RPCIA_BIT_READ_NOT_WRITE];

    // ------------------------------------------------------------
    // Index to store entry
    // ------------------------------------------------------------
    // Store offsets of the three 24-byte groups
    localparam logic [7:0] ent_dtc = 8'(RPCIA_NUM_CHAN);
    localparam logic [7:0] ent_stc = 8'(2 * RPCIA_NUM_CHAN);
    localparam logic [6:0] ix_end = RPCIA_IX_STC_FIRST + 7'(RPCIA_NUM_CHAN);
    function automatic logic [7:0] map_index(input logic [6:0] ix);
        logic [7:0] res;
        res = 8'hff;
        if (ix >= RPCIA_IX_PCM_FIRST && ix < RPCIA_IX_DTC_FIRST) begin
            res = {1'b0, ix - RPCIA_IX_PCM_FIRST};
        end else if (ix >= RPCIA_IX_DTC_FIRST && ix < RPCIA_IX_STC_FIRST) begin
            res = {1'b0, ix - RPCIA_IX_DTC_FIRST} + ent_dtc;
        end else if (ix >= RPCIA_IX_STC_FIRST && ix < ix_end) begin
            res = {1'b0, ix - RPCIA_IX_STC_FIRST} + ent_stc;
        end
        return res;
    endfunction : map_index

    logic [7:0] mapped;
    assign mapped = map_index(req_index);
    assign entry = mapped[6:0];
    assign entry_valid = !mapped[7];

    // Writes while busy neither land in the register nor start a new access
    assign start_access = bus_wr && WB_REQ.adr == RPCIA_ADR_ADDR_CTRL
        && access_type_select && !busy;
    assign done = busy && busy_cnt == 4'(RPCIA_ACCESS_CYCLES - 1);

    // ------------------------------------------------------------
    // Configuration register
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            access_type_select <= RPCIA_RST_CONFIG[RPCIA_BIT_ACCESS_TYPE_SELECT];
            per_channel_func_enable <= RPCIA_RST_CONFIG[RPCIA_BIT_PER_CHANNEL_FUNC_ENABLE];
        end else if (bus_wr && WB_REQ.adr == RPCIA_ADR_CONFIG) begin
            // Only two bits stored; the rest are dropped
            access_type_select <= WB_REQ.dat[RPCIA_BIT_ACCESS_TYPE_SELECT];
            per_channel_func_enable <= WB_REQ.dat[RPCIA_BIT_PER_CHANNEL_FUNC_ENABLE];
        end
    end

    // ------------------------------------------------------------
    // Address control register
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            addr_ctrl <= RPCIA_RST_ADDR_CTRL;
        end else if (bus_wr && WB_REQ.adr == RPCIA_ADR_ADDR_CTRL && !busy) begin
            addr_ctrl <= WB_REQ.dat[7:0];
        end
    end

    // ------------------------------------------------------------
    // Busy timer
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            busy <= 1'b0;
            busy_cnt <= 4'h0;
        end else if (start_access) begin
            busy <= 1'b1;
            busy_cnt <= 4'h0;
        end else if (done) begin
            busy <= 1'b0;
            busy_cnt <= 4'h0;
        end else if (busy) begin
            busy_cnt <= busy_cnt + 4'h1;
        end
    end

    // ------------------------------------------------------------
    // Data buffer: software writes, read results land at completion
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            data_buf <= RPCIA_RST_DATA_BUF;
        end else if (done && req_read) begin
            data_buf <= entry_valid ? store[entry] : 8'h00;
        end else if (bus_wr && WB_REQ.adr == RPCIA_ADR_DATA_BUF && !busy) begin
            data_buf <= WB_REQ.dat[7:0];
        end
    end

    // ------------------------------------------------------------
    // Per-channel store, one flop byte per entry
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < RPCIA_NUM_ENTRY; gi++) begin : g_store
            always_ff @(posedge CLK_SYS or negedge RESET_N) begin
                if (!RESET_N) begin
                    store[gi] <= 8'h00;
                end else if (done && !req_read && entry_valid && entry == 7'(gi)) begin
                    store[gi] <= data_buf;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Wishbone slave: ack one cycle after the strobe, zero for holes
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            wb_ack <= 1'b0;
            wb_dat <= 32'h0;
        end else begin
            wb_ack <= bus_hit;
            wb_dat <= 32'h0;
            if (bus_hit && !WB_REQ.we) begin
                case (WB_REQ.adr)
                    RPCIA_ADR_CONFIG: wb_dat <= {30'h0, access_type_select,
                        per_channel_func_enable};
                    RPCIA_ADR_STATUS: wb_dat <= {24'h0, busy, 7'h0};
                    RPCIA_ADR_ADDR_CTRL: wb_dat <= {24'h0, addr_ctrl};
                    RPCIA_ADR_DATA_BUF: wb_dat <= {24'h0, data_buf};
                    default: wb_dat <= 32'h0;
                endcase
            end
        end
    end
    assign WB_RSP.ack = wb_ack;
    assign WB_RSP.dat = wb_dat;

    // ------------------------------------------------------------
    // Stream conditioning: bit 7 of control picks data code, bit 6 signalling
    // ------------------------------------------------------------
    logic [7:0] ctl_byte;
    logic [7:0] dtc_byte;
    logic [7:0] stc_byte;
    logic chan_ok;
    // Seven-bit sums: a six-bit sum wraps for channel 16 and up
    logic [6:0] dtc_ix;
    logic [6:0] stc_ix;
    assign chan_ok = CHAN_NUM < 5'(RPCIA_NUM_CHAN);
    assign dtc_ix = 7'(CHAN_NUM) + ent_dtc[6:0];
    assign stc_ix = 7'(CHAN_NUM) + ent_stc[6:0];
    assign ctl_byte = chan_ok ? store[CHAN_NUM] : 8'h00;
    assign dtc_byte = chan_ok ? store[dtc_ix] : 8'h00;
    assign stc_byte = chan_ok ? store[stc_ix] : 8'h00;

    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            BACKPLANE_RX_PCM_OUT <= 8'h00;
            BACKPLANE_RX_SIG_OUT <= 4'h0;
        end else if (per_channel_func_enable) begin
            BACKPLANE_RX_PCM_OUT <= ctl_byte[7] ? dtc_byte : RX_PCM_IN;
            BACKPLANE_RX_SIG_OUT <= ctl_byte[6] ? stc_byte[3:0] : RX_SIG_IN;
        end else begin
            BACKPLANE_RX_PCM_OUT <= RX_PCM_IN;
            BACKPLANE_RX_SIG_OUT <= RX_SIG_IN;
        end
    end

    // ------------------------------------------------------------
    // Assertion helpers
    // ------------------------------------------------------------
    // Counted apart from busy_cnt, so a broken timer cannot hide itself
    logic [4:0] busy_len;
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            busy_len <= 5'h00;
        end else if (busy) begin
            busy_len <= busy_len + 5'h01;
        end else begin
            busy_len <= 5'h00;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_start;
        start_access;
    endsequence
    sequence s_busy_run;
        busy [*8];
    endsequence
    sequence s_busy_end;
        busy && done ##1 !busy;
    endsequence
    sequence s_status_read;
        bus_hit && !WB_REQ.we && WB_REQ.adr == RPCIA_ADR_STATUS;
    endsequence

    a_busy_on_start: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        s_start |=> s_busy_run) else $error("busy not held after start");
    a_busy_time_bound: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        s_start |=> ##11 s_busy_end) else $error("access time wrong");
    a_busy_len_cap: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        busy |-> busy_len < 5'(RPCIA_ACCESS_CYCLES)) else $error("busy held too long");
    a_busy_falls_done: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        $fell(busy) |-> $past(done)) else $error("busy fell early");
    a_reset_config: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        $rose(RESET_N) |-> !access_type_select) else $error("config not cleared");
    a_no_start_direct: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        !access_type_select && !busy |=> !busy) else $error("start in direct mode");
    a_config_write: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        bus_wr && WB_REQ.adr == RPCIA_ADR_CONFIG |=> access_type_select
        == $past(WB_REQ.dat[RPCIA_BIT_ACCESS_TYPE_SELECT])) else $error("config bit lost");
    a_ctrl_write: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        bus_wr && WB_REQ.adr == RPCIA_ADR_ADDR_CTRL && !busy |=> addr_ctrl
        == $past(WB_REQ.dat[7:0])) else $error("address control not stored");
    a_ctrl_hold_busy: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        busy |=> $stable(addr_ctrl)) else $error("address control changed while busy");
    a_read_data_lands: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        done && req_read && entry_valid |=> data_buf == $past(store[entry]))
        else $error("read data missing");
    a_dbuf_hold_busy: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        busy && !done |=> $stable(data_buf)) else $error("data buffer changed while busy");
    a_hole_read_zero: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        done && req_read && !entry_valid |=> data_buf == 8'h00)
        else $error("hole read not zero");
    a_store_write: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        done && !req_read && entry_valid |=> store[$past(entry)] == $past(data_buf))
        else $error("store write missing");
    a_pass_through: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        !per_channel_func_enable |=> BACKPLANE_RX_PCM_OUT == $past(RX_PCM_IN))
        else $error("data modified while disabled");
    a_sig_pass: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        !per_channel_func_enable |=> BACKPLANE_RX_SIG_OUT == $past(RX_SIG_IN))
        else $error("signalling modified while disabled");
    a_trunk_replace: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        per_channel_func_enable && ctl_byte[7] |=> BACKPLANE_RX_PCM_OUT == $past(dtc_byte))
        else $error("trunk code not applied");
    a_pcm_pass_ctl: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        per_channel_func_enable && !ctl_byte[7] |=> BACKPLANE_RX_PCM_OUT == $past(RX_PCM_IN))
        else $error("clear channel data modified");
    a_sig_replace: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        per_channel_func_enable && ctl_byte[6] |=> BACKPLANE_RX_SIG_OUT == $past(stc_byte[3:0]))
        else $error("signalling code not applied");
    a_status_read: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        s_status_read |=> wb_ack && wb_dat[6:0] == 7'h0)
        else $error("status unused bits nonzero");
    a_status_busy: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        s_status_read |=> wb_dat[RPCIA_BIT_BUSY] == $past(busy)) else $error("busy bit misread");
endmodule : rpcia_top

// file: tb/test_rx_per_channel_indirect_access.sv
/*
 Self-checking bench for the receive per-channel indirect access block.
 Assumes rpcia_pkg and rpcia_top are compiled first; one 20 MHz clock.
*/
`timescale 1ns/1ps
module test_rx_per_channel_indirect_access;
    import rpcia_pkg::*;
    logic CLK_SYS = 1'b0;
    logic RESET_N = 1'b0;
    rpcia_wb_req_t WB_REQ = '0;
    rpcia_wb_rsp_t WB_RSP;
    logic [4:0] CHAN_NUM = 5'h00;
    logic [7:0] RX_PCM_IN = 8'h00;
    logic [3:0] RX_SIG_IN = 4'h0;
    logic [7:0] BACKPLANE_RX_PCM_OUT;
    logic [3:0] BACKPLANE_RX_SIG_OUT;
    logic [32:0] exp_q[$];
    logic [6:0] ix[8] = '{7'h01, 7'h18, 7'h19, 7'h30, 7'h31, 7'h48, 7'h00, 7'h49};
    int bad_count = 0;
    int compares = 0;
    rpcia_top dut (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .WB_REQ(WB_REQ), .WB_RSP(WB_RSP),
        .CHAN_NUM(CHAN_NUM), .RX_PCM_IN(RX_PCM_IN), .RX_SIG_IN(RX_SIG_IN),
        .BACKPLANE_RX_PCM_OUT(BACKPLANE_RX_PCM_OUT),
        .BACKPLANE_RX_SIG_OUT(BACKPLANE_RX_SIG_OUT));
    initial begin
        forever #25 CLK_SYS = ~CLK_SYS;
    end
    // ------------------------------------------------------------
    // Compare and verdict
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        compares++;
        if (seen !== want) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : chk
    task automatic summarize;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize
    // Read answers are matched against the oldest note
    always @(posedge CLK_SYS) begin
        if (WB_RSP.ack === 1'b1 && WB_REQ.we === 1'b0 && exp_q.size() > 0) begin
            if (exp_q[0][32]) begin
                chk(WB_RSP.dat, exp_q[0][31:0]);
            end
            void'(exp_q.pop_front());
        end
    end
    // ------------------------------------------------------------
    // Bus cycles
    // ------------------------------------------------------------
    task automatic bus(input logic we, input logic [9:0] adr, input logic [7:0] d,
            output logic [31:0] q);
        int n;
        n = 0;
        @(posedge CLK_SYS);
        WB_REQ <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: adr, dat: {24'h0, d}};
        do begin
            @(posedge CLK_SYS);
            n++;
        end while (WB_RSP.ack !== 1'b1 && n < 50);
        if (n >= 50) begin
            bad_count++;
            summarize();
        end
        q = WB_RSP.dat;
        WB_REQ <= '0;
    endtask : bus
    task automatic wr(input logic [9:0] adr, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, adr, d, q);
    endtask : wr
    task automatic rd(input logic [9:0] adr, input logic [31:0] want);
        logic [31:0] q;
        exp_q.push_back({1'b1, want});
        bus(1'b0, adr, 8'h00, q);
    endtask : rd
    // Starts one access, pokes the buffer while busy, polls until idle
    task automatic access(input logic rnw, input logic [6:0] idx);
        logic [31:0] q;
        logic first;
        realtime t0;
        int k;
        k = 0;
        wr(RPCIA_ADR_ADDR_CTRL, {rnw, idx});
        t0 = $realtime;
        wr(RPCIA_ADR_DATA_BUF, 8'h3c);
        wr(RPCIA_ADR_ADDR_CTRL, 8'h7f);
        do begin
            exp_q.push_back(33'h0);
            bus(1'b0, RPCIA_ADR_STATUS, 8'h00, q);
            if (k == 0) begin
                first = q[7];
            end
            k++;
        end while (q[7] === 1'b1 && k < 40);
        chk(32'(first), 32'h1);
        chk(32'(q[7]), 32'h0);
        chk(32'($realtime - t0 <= RPCIA_ACCESS_TIME_NS + 150), 32'h1);
    endtask : access
    task automatic strm(input logic [4:0] ch, input logic sub);
        logic [7:0] p;
        logic [3:0] s;
        p = 8'($urandom());
        s = 4'($urandom());
        @(posedge CLK_SYS);
        CHAN_NUM <= ch;
        RX_PCM_IN <= p;
        RX_SIG_IN <= s;
        @(posedge CLK_SYS);
        @(negedge CLK_SYS);
        chk(32'(BACKPLANE_RX_PCM_OUT), sub ? 32'ha5 : 32'(p));
        chk(32'(BACKPLANE_RX_SIG_OUT), sub ? 32'hc : 32'(s));
    endtask : strm
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        logic [7:0] d;
        void'($urandom(211));
        repeat (5) @(posedge CLK_SYS);
        RESET_N <= 1'b1;
        rd(RPCIA_ADR_CONFIG, 32'h0);
        rd(RPCIA_ADR_STATUS, 32'h0);
        rd(RPCIA_ADR_ADDR_CTRL, 32'h0);
        rd(RPCIA_ADR_DATA_BUF, 32'h0);
        rd(10'h000, 32'h0);
        $display("test reset values done");
        wr(RPCIA_ADR_CONFIG, 8'hfd);
        rd(RPCIA_ADR_CONFIG, 32'h1);
        wr(RPCIA_ADR_STATUS, 8'hff);
        wr(RPCIA_ADR_ADDR_CTRL, 8'h85);
        rd(RPCIA_ADR_STATUS, 32'h0);
        rd(RPCIA_ADR_ADDR_CTRL, 32'h85);
        $display("test direct mode done");
        wr(RPCIA_ADR_CONFIG, 8'h02);
        for (int i = 0; i < 8; i++) begin
            d = 8'($urandom());
            wr(RPCIA_ADR_DATA_BUF, d);
            access(1'b0, ix[i]);
            rd(RPCIA_ADR_DATA_BUF, 32'(d));
            access(1'b1, ix[i]);
            rd(RPCIA_ADR_DATA_BUF, (ix[i] != 0 && ix[i] <= 7'h48) ? 32'(d) : 32'h0);
            rd(RPCIA_ADR_ADDR_CTRL, 32'({1'b1, ix[i]}));
        end
        $display("test indirect access done");
        // Channel 2 substitutes both codes, channel 3 stays clear
        wr(RPCIA_ADR_DATA_BUF, 8'hc0);
        access(1'b0, 7'h03);
        wr(RPCIA_ADR_DATA_BUF, 8'ha5);
        access(1'b0, 7'h1b);
        wr(RPCIA_ADR_DATA_BUF, 8'h0c);
        access(1'b0, 7'h33);
        strm(5'h02, 1'b0);
        wr(RPCIA_ADR_CONFIG, 8'h03);
        strm(5'h02, 1'b1);
        strm(5'h03, 1'b0);
        $display("test per channel streams done");
        // Mid-run reset must clear the configuration again
        @(posedge CLK_SYS);
        RESET_N <= 1'b0;
        repeat (5) @(posedge CLK_SYS);
        RESET_N <= 1'b1;
        rd(RPCIA_ADR_CONFIG, 32'h0);
        rd(RPCIA_ADR_ADDR_CTRL, 32'h0);
        $display("test mid-run reset done");
        summarize();
    end
    initial begin
        repeat (8000) @(posedge CLK_SYS);
        bad_count++;
        summarize();
    end
endmodule : test_rx_per_channel_indirect_access
